// File: rtl/fiu_defines.svh
// Constants of the fault indication unit: register offsets, fields, resets, timing.
// Assumes a 25 MHz APB clock; included only by fiu_top, not by the package or the blinker.
// Behaviour
// - Fast 4 Hz LED blink for errors that need zero calibration.
// - Slow 1 Hz LED blink for wrong configuration with failed calibration.
// - LED lit steadily for faults that prevent starting.
// - Default relay: off while blinking, on if start bit rises there.
// - Default relay: energized in the steady-lit alarm state.
// - Inverted relay polarity setting inverts every relay state.
// - Alarm flag set on fault; compact word carries code in bits 0-3.
// - Extended format carries code in bits 8-11 of word two.
// - During alarm the analog output shows a fault level, not temperature.
// - Thirteen distinct fault levels, each tied to an error code.
// - Blinking classes toggle analog output at 1 Hz with full scale.
// - Start bit during blinking class freezes analog output.
// - Alarm stays latched until reset bit or power cycle.
// - Outside alarms output is linear, 0 V to full scale temperature.
`ifndef FIU_DEFINES_SVH
`define FIU_DEFINES_SVH

`define FIU_CLK_HZ          25000000
`define FIU_FAST_HZ         4
`define FIU_SLOW_HZ         1
// Half periods of the blink rates, in clock cycles
`define FIU_FAST_HALF       (`FIU_CLK_HZ / (2 * `FIU_FAST_HZ))
`define FIU_SLOW_HALF       (`FIU_CLK_HZ / (2 * `FIU_SLOW_HZ))

`define FIU_OFS_ERROR       12'h000
`define FIU_OFS_CTRL        12'h004
`define FIU_OFS_TEMP        12'h008
`define FIU_OFS_STATUS      12'h00c
`define FIU_OFS_IRQ_STAT    12'h010
`define FIU_OFS_IRQ_MASK    12'h014
`define FIU_OFS_CYCLIC      12'h018
`define FIU_OFS_ANALOG      12'h01c

// Control register fields
`define FIU_CTRL_START      0
`define FIU_CTRL_RESET      1
`define FIU_CTRL_RELAY_INV  2
`define FIU_CTRL_EXTENDED   3
`define FIU_CTRL_SCALE500   4
`define FIU_CTRL_RESET_VAL  32'h0000_0000

// Interrupt bits
`define FIU_IRQ_RAISED      0
`define FIU_IRQ_CLEARED     1
`define FIU_IRQ_WIDTH       2

`define FIU_DAC_FULL        12'hfff
`define FIU_TEMP_300        16'h012c
`define FIU_TEMP_500        16'h01f4
`define FIU_NUM_LEVELS      13

`endif

// File: rtl/fiu_pkg.sv
// Types of the fault indication unit.
// Assumes nothing; does not use the defines header.
package fiu_pkg;
    typedef enum logic [3:0] {
        FIU_NONE   = 4'b0001,
        FIU_FAST   = 4'b0010,
        FIU_SLOW   = 4'b0100,
        FIU_STEADY = 4'b1000
    } fiu_class_type;
endpackage

// File: rtl/fiu_blinker.sv
// Free-running square wave toggling every HALF cycles.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module fiu_blinker #(
    parameter int HALF = 2
) (
    input  wire logic pclk,    // Clock
    input  wire logic presetn, // Async reset, active low
    output logic      wave     // Square wave
);
    // A zero or negative half period cannot be counted
    if (HALF < 1) begin : g_bad_half
        $error("fiu_blinker: HALF must be at least 1");
    end

    logic [31:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 32'h0000_0000;
            wave  <= 1'b0;
        end else if (cnt_q == 32'(HALF - 1)) begin
            cnt_q <= 32'h0000_0000;
            wave  <= ~wave;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end
endmodule // fiu_blinker

// File: rtl/fiu_top.sv
// Fault indication: classifies error codes, drives LED, relay, cyclic data, analog level.
// Assumes an APB master; error code and temperature written by control firmware.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`include "fiu_defines.svh"
module fiu_top #(
    parameter int FAST_HALF = `FIU_FAST_HALF,
    parameter int SLOW_HALF = `FIU_SLOW_HALF
) (
    input  wire logic        pclk,        // Clock, 25 MHz
    input  wire logic        presetn,     // Async reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB enable
    input  wire logic        pwrite,      // APB direction
    input  wire logic [11:0] paddr,       // APB address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error
    output logic             alarm_led,   // Red alarm LED
    output logic             alarm_relay, // Relay energized
    output logic      [15:0] cyclic_word1,// Compact / first cyclic word
    output logic      [15:0] cyclic_word2,// Second cyclic word
    output logic      [11:0] analog_out,  // DAC code, full scale 10 V
    output logic             irq          // Interrupt, level
);
    // Blink half periods must be positive and the slow one not shorter
    if (FAST_HALF < 1 || SLOW_HALF < FAST_HALF) begin : g_bad_half
        $error("fiu_top: bad blink half periods");
    end

    logic [9:0]  err_code_q;
    logic [31:0] ctrl_q;
    logic [15:0] temp_q;
    logic [9:0]  latched_q;
    logic        frozen_q;
    logic        start_prev_q;
    logic        start_seen_q;
    logic [11:0] frozen_lvl_q;
    logic [`FIU_IRQ_WIDTH-1:0] irq_stat_q;
    logic [`FIU_IRQ_WIDTH-1:0] irq_mask_q;
    logic        fast_wave;
    logic        slow_wave;
    logic        alarm_seen_q;
    logic [11:0] analog_d;
    logic [11:0] temp_lvl;
    fiu_pkg::fiu_class_type cls;

    wire wr = psel && penable && pwrite;
    wire start_bit = ctrl_q[`FIU_CTRL_START];
    wire reset_bit = ctrl_q[`FIU_CTRL_RESET];
    wire alarm = (latched_q != 10'h000);

    fiu_blinker #(.HALF(FAST_HALF)) u_fast (.pclk(pclk), .presetn(presetn), .wave(fast_wave));
    fiu_blinker #(.HALF(SLOW_HALF)) u_slow (.pclk(pclk), .presetn(presetn), .wave(slow_wave));

    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_code_q <= 10'h000;
            ctrl_q     <= `FIU_CTRL_RESET_VAL;
            temp_q     <= 16'h0000;
            irq_mask_q <= '0;
        end else if (wr) begin
            case (paddr)
                `FIU_OFS_ERROR:    err_code_q <= pwdata[9:0];
                `FIU_OFS_CTRL:     ctrl_q     <= {27'h0000000, pwdata[4:0]};
                `FIU_OFS_TEMP:     temp_q     <= pwdata[15:0];
                `FIU_OFS_IRQ_MASK: irq_mask_q <= pwdata[`FIU_IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_q <= 10'h000;
        end else if (reset_bit) begin
            latched_q <= 10'h000;
        end else if (latched_q == 10'h000 && err_code_q != 10'h000) begin
            latched_q <= err_code_q;
        end
    end

    // Classification of latched code
    function automatic fiu_pkg::fiu_class_type classify(input logic [9:0] c);
        fiu_pkg::fiu_class_type k;
        k = fiu_pkg::FIU_NONE;
        if (c == 10'd8 || c == 10'd9 || (c >= 10'd104 && c <= 10'd106) ||
            c == 10'd211 || c == 10'd302 || c == 10'd303)
            k = fiu_pkg::FIU_FAST;
        else if ((c >= 10'd10 && c <= 10'd12) || (c >= 10'd111 && c <= 10'd114))
            k = fiu_pkg::FIU_SLOW;
        else if (c != 10'd0)
            k = fiu_pkg::FIU_STEADY;
        return k;
    endfunction

    assign cls = classify(latched_q);
    wire blink_cls = (cls == fiu_pkg::FIU_FAST) || (cls == fiu_pkg::FIU_SLOW);

    function automatic logic [3:0] level_index(input logic [9:0] c);
        logic [3:0] i;
        i = 4'h0;
        if (c <= 10'd12)
            i = c[3:0];
        else if (c >= 10'd101 && c <= 10'd999)
            i = 4'(((c - 10'd100) % 10'd12) + 10'd1);
        return i;
    endfunction

    wire [3:0]  lvl_idx = level_index(latched_q);
    // Product needs 16 bits; kept at 24 so it cannot wrap
    wire [11:0] fault_lvl = 12'(({20'h00000, lvl_idx} * 24'd4095) / 24'(`FIU_NUM_LEVELS + 1));

    // Start edge tracking and analog freeze
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_prev_q <= 1'b0;
            start_seen_q <= 1'b0;
            frozen_q     <= 1'b0;
            frozen_lvl_q <= 12'h000;
        end else begin
            start_prev_q <= start_bit;
            if (!alarm) begin
                start_seen_q <= 1'b0;
                frozen_q     <= 1'b0;
            end else if (blink_cls && start_bit && !start_prev_q && !frozen_q) begin
                start_seen_q <= 1'b1;
                frozen_q     <= 1'b1;
                frozen_lvl_q <= analog_d;
            end
        end
    end

    always_comb begin
        if (ctrl_q[`FIU_CTRL_SCALE500])
            temp_lvl = (temp_q >= `FIU_TEMP_500) ? `FIU_DAC_FULL :
                       12'((32'(temp_q) * 32'd4095) / 32'(`FIU_TEMP_500));
        else
            temp_lvl = (temp_q >= `FIU_TEMP_300) ? `FIU_DAC_FULL :
                       12'((32'(temp_q) * 32'd4095) / 32'(`FIU_TEMP_300));
        if (!alarm)
            analog_d = temp_lvl;
        else if (frozen_q)
            analog_d = frozen_lvl_q;
        // 1 Hz toggle to full scale
        else if (blink_cls)
            analog_d = slow_wave ? `FIU_DAC_FULL : fault_lvl;
        else
            analog_d = fault_lvl;
    end

    // Outputs
    logic relay_default;
    always_comb begin
        case (cls)
            fiu_pkg::FIU_FAST:   relay_default = start_seen_q;
            fiu_pkg::FIU_SLOW:   relay_default = start_seen_q;
            fiu_pkg::FIU_STEADY: relay_default = 1'b1;
            fiu_pkg::FIU_NONE:   relay_default = 1'b0;
            default:             relay_default = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_led    <= 1'b0;
            alarm_relay  <= 1'b0;
            cyclic_word1 <= 16'h0000;
            cyclic_word2 <= 16'h0000;
            analog_out   <= 12'h000;
        end else begin
            case (cls)
                fiu_pkg::FIU_FAST:   alarm_led <= fast_wave;
                fiu_pkg::FIU_SLOW:   alarm_led <= slow_wave;
                fiu_pkg::FIU_STEADY: alarm_led <= 1'b1;
                fiu_pkg::FIU_NONE:   alarm_led <= 1'b0;
                default:             alarm_led <= 1'b0;
            endcase
            alarm_relay <= relay_default ^ ctrl_q[`FIU_CTRL_RELAY_INV];
            if (ctrl_q[`FIU_CTRL_EXTENDED]) begin
                cyclic_word1 <= {alarm, 15'h0000};
                cyclic_word2 <= {4'h0, (alarm ? lvl_idx : 4'h0), 8'h00};
            end else begin
                cyclic_word1 <= alarm ? {1'b1, 11'h000, lvl_idx} : {1'b0, temp_q[14:0]};
                cyclic_word2 <= 16'h0000;
            end
            analog_out <= analog_d;
        end
    end

    // Interrupt status, write one to clear, set wins
    wire ev_raise = alarm && !alarm_seen_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_seen_q <= 1'b0;
            irq_stat_q   <= '0;
        end else begin
            alarm_seen_q <= alarm;
            for (int i = 0; i < `FIU_IRQ_WIDTH; i++) begin
                if (wr && paddr == `FIU_OFS_IRQ_STAT && pwdata[i])
                    irq_stat_q[i] <= 1'b0;
            end
            if (ev_raise)
                irq_stat_q[`FIU_IRQ_RAISED] <= 1'b1;
            if (!alarm && alarm_seen_q)
                irq_stat_q[`FIU_IRQ_CLEARED] <= 1'b1;
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // APB read side, zero wait states
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    always_comb begin
        case (paddr)
            `FIU_OFS_ERROR:    prdata = {22'h000000, err_code_q};
            `FIU_OFS_CTRL:     prdata = ctrl_q;
            `FIU_OFS_TEMP:     prdata = {16'h0000, temp_q};
            `FIU_OFS_STATUS:   prdata = {18'h00000, cls, latched_q};
            `FIU_OFS_IRQ_STAT: prdata = {30'h00000000, irq_stat_q};
            `FIU_OFS_IRQ_MASK: prdata = {30'h00000000, irq_mask_q};
            `FIU_OFS_CYCLIC:   prdata = {cyclic_word2, cyclic_word1};
            `FIU_OFS_ANALOG:   prdata = {20'h00000, analog_out};
            default:           prdata = 32'h0000_0000;
        endcase
    end
endmodule // fiu_top

// File: bench/fiu_plc_model.sv
// Fieldbus master model that reads the cyclic words.
// Assumes the bench tells it which protocol format is set.
`timescale 1ns/1ps
module fiu_plc_model (
    input  wire logic        pclk,         // Clock
    input  wire logic [15:0] cyclic_word1, // Word one
    input  wire logic [15:0] cyclic_word2, // Word two
    input  wire logic        ext,          // Extended format
    output logic             al_seen,      // Alarm flag read
    output logic      [3:0]  code_seen     // Code field read
);
    always_ff @(posedge pclk) begin
        al_seen   <= cyclic_word1[15];
        code_seen <= ext ? cyclic_word2[11:8] : cyclic_word1[3:0];
    end
endmodule // fiu_plc_model

// File: bench/fiu_checker.sv
// Port checker of the fault indication unit.
// Assumes a bind onto fiu_top; shadows the control word.
`timescale 1ns/1ps
module fiu_checker #(
    parameter int FAST_HALF = 2,
    parameter int SLOW_HALF = 2
) (
    input wire logic        pclk,         // Clock
    input wire logic        presetn,      // Reset
    input wire logic        psel,         // Select
    input wire logic        penable,      // Enable
    input wire logic        pwrite,       // Write
    input wire logic [11:0] paddr,        // Address
    input wire logic [31:0] pwdata,       // Write data
    input wire logic [31:0] prdata,       // Read data
    input wire logic        pready,       // Ready
    input wire logic        pslverr,      // Error
    input wire logic        alarm_led,    // LED
    input wire logic        alarm_relay,  // Relay
    input wire logic [15:0] cyclic_word1, // Word one
    input wire logic [15:0] cyclic_word2, // Word two
    input wire logic [11:0] analog_out,   // DAC code
    input wire logic        irq           // Interrupt
);
    logic [4:0]  ctrl_q;
    logic [31:0] lit_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctrl_q <= 5'h00;
        else if (psel && penable && pwrite && paddr == 12'h004) ctrl_q <= pwdata[4:0];
    end
    // Unbroken lit time tells the steady class apart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lit_q <= 32'h0;
        else lit_q <= alarm_led ? lit_q + 32'h1 : 32'h0;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence access_s;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence steady_s;
        alarm_led && cyclic_word1[15] && lit_q > 2 * SLOW_HALF;
    endsequence
    apb_ready_a: assert property (access_s |-> pready)
        else $error("access without ready");
    apb_error_a: assert property (access_s |-> !pslverr)
        else $error("unexpected slave error");
    led_flag_a: assert property (alarm_led |-> cyclic_word1[15])
        else $error("LED lit without alarm flag");
    flag_hold_a: assert property ($fell(cyclic_word1[15]) |-> ctrl_q[1] || $past(ctrl_q[1]))
        else $error("alarm cleared without reset bit");
    compact_code_a: assert property (cyclic_word1[15] && !ctrl_q[3] |->
        cyclic_word1[14:4] == 11'h000 && cyclic_word1[3:0] != 4'h0)
        else $error("compact word malformed");
    ext_code_a: assert property (cyclic_word1[15] && ctrl_q[3] |-> cyclic_word2[11:8] != 4'h0)
        else $error("extended code missing");
    steady_relay_a: assert property (steady_s |-> alarm_relay != ctrl_q[2])
        else $error("relay wrong in steady alarm");
    steady_level_a: assert property (steady_s |-> $stable(analog_out) && analog_out != 12'hfff)
        else $error("steady fault level moved");
endmodule // fiu_checker

// File: bench/fault_indication_unit_tb.sv
// Self-checking bench of the fault indication unit.
// Assumes fiu_top, the checker and the fieldbus model; short blink counts.
`timescale 1ns/1ps
module fault_indication_unit_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        alarm_led, alarm_relay, irq, ext, al_seen;
    logic [11:0] paddr, analog_out;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] cyclic_word1, cyclic_word2;
    logic [3:0]  code_seen;
    int          failures, n_tests, seed;
    int          codes[24] = '{3, 8, 9, 10, 11, 12, 104, 105, 106, 111, 112, 113,
                               114, 211, 302, 303, 801, 950, 1, 7, 101, 108, 201, 307};
    fiu_top #(.FAST_HALF(4), .SLOW_HALF(16)) uut (
        .pclk         (pclk),
        .presetn      (presetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .alarm_led    (alarm_led),
        .alarm_relay  (alarm_relay),
        .cyclic_word1 (cyclic_word1),
        .cyclic_word2 (cyclic_word2),
        .analog_out   (analog_out),
        .irq          (irq)
    );
    fiu_plc_model plc (
        .pclk         (pclk),
        .cyclic_word1 (cyclic_word1),
        .cyclic_word2 (cyclic_word2),
        .ext          (ext),
        .al_seen      (al_seen),
        .code_seen    (code_seen)
    );
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [3:0] cls(input int c);
        if (c inside {8, 9, [104:106], 211, 302, 303}) return 4'h2;
        if (c inside {[10:12], [111:114]}) return 4'h4;
        return 4'h8;
    endfunction
    function automatic logic [3:0] idx(input int c);
        return c <= 12 ? c[3:0] : 4'(((c - 100) % 12) + 1);
    endfunction
    task automatic alarm(input int c, input logic [4:0] cb);
        logic [3:0]  k;
        logic [11:0] v, a;
        logic        l, m;
        int          t, s, r, f;
        k = cls(c);
        s = cb[4] ? 500 : 300;
        t = {$random(seed)} % (s + 1);
        m = $random(seed);
        ext <= cb[3];
        bus(1, 12'h014, {30'h0, m, m});
        bus(1, 12'h008, t);
        bus(1, 12'h004, cb);
        bus(1, 12'h000, c);
        repeat (4) @(posedge pclk);
        bus(0, 12'h00c, 0);
        chk("class", q[13:10], k);
        chk("flag", al_seen, 1);
        chk("code", code_seen, idx(c));
        chk("relay", alarm_relay, (k == 4'h8) ^ cb[2]);
        chk("irq", irq, m);
        bus(1, 12'h010, 3);
        chk("irq clr", irq, 0);
        l = alarm_led;
        r = 0;
        f = 0;
        v = 0;
        repeat (64) begin
            @(negedge pclk);
            r += alarm_led & ~l;
            l = alarm_led;
            if (analog_out === 12'hfff) f++;
            else v = analog_out;
        end
        @(posedge pclk);
        chk("blinks", r, k == 4'h2 ? 8 : k == 4'h4 ? 2 : 0);
        chk("full", f, k == 4'h8 ? 0 : 32);
        chk("level", v, 12'((idx(c) * 4095) / 14));
        bus(1, 12'h004, cb | 5'h01);
        repeat (4) @(posedge pclk);
        a = analog_out;
        chk("relay st", alarm_relay, !cb[2]);
        repeat (40) @(posedge pclk);
        chk("freeze", analog_out, a);
        bus(1, 12'h000, 0);
        repeat (4) @(posedge pclk);
        chk("latch", al_seen, 1);
        bus(1, 12'h004, cb | 5'h02);
        repeat (4) @(posedge pclk);
        bus(1, 12'h004, cb);
        chk("led off", alarm_led, 0);
        chk("flag off", al_seen, 0);
        chk("irq back", irq, m);
        chk("linear", (int'(analog_out) - t * 4095 / s) inside {[-1:1]}, 1);
        if (!cb[3]) chk("word1", cyclic_word1, {1'b0, t[14:0]});
        bus(1, 12'h010, 3);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge pclk);
        failures++;
        finish_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ext} = '0;
        failures = 0;
        n_tests = 0;
        seed = 32'hfb66;
        presetn = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        bus(0, 12'h004, 0);
        chk("ctrl rst", q, 0);
        bus(1, 12'h020, 32'hffff_ffff);
        bus(0, 12'h020, 0);
        chk("unmapped", q, 0);
        foreach (codes[i]) alarm(codes[i], i == 0 ? 5'h00 : 5'h1c & $random(seed));
        finish_test();
    end
endmodule // fault_indication_unit_tb
bind fiu_top fiu_checker #(.FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF)) chk (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .alarm_led    (alarm_led),
    .alarm_relay  (alarm_relay),
    .cyclic_word1 (cyclic_word1),
    .cyclic_word2 (cyclic_word2),
    .analog_out   (analog_out),
    .irq          (irq)
);
